//--- sipo_driver_map.svh
// Constant map for the serial-in parallel-out open-drain driver
`ifndef SIPO_DRIVER_MAP_SVH
`define SIPO_DRIVER_MAP_SVH
`define STAGE_COUNT     12
`define STAGE_MSB       11
`define LAST_STAGE      11
`define STAGE_ZERO      12'h000
`define STAGE_ONES      12'hFFF
`define FRAME_BITS      4'hC
`define FRAME_CNT_ZERO  4'h0
`define FRAME_CNT_ONE   4'h1
`endif

//--- sipo_driver_pkg.sv
// Types shared by the serial-in parallel-out driver files
package sipo_driver_pkg;
  typedef logic [11:0] stage_word_t;
  typedef enum logic [1:0]
  {
    FILL_EMPTY   = 2'h0,
    FILL_PARTIAL = 2'h1,
    FILL_FULL    = 2'h2,
    FILL_LATCHED = 2'h3
  } fill_state_t;
endpackage

//--- edge_catch.sv
// Rising-edge detector for a pin sampled on the system clock
module edge_catch
(
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic clock_en,
  input  wire logic level_in,
  output logic      rise_pulse,
  output logic      level_now
);
  logic last_reg;
  logic last_next;

  always_comb
  begin
    last_next = last_reg;
    if (clock_en)
    begin
      last_next = level_in;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      last_reg <= 1'b0;
    end
    else
    begin
      last_reg <= last_next;
    end
  end

  // Pins are synchronous to the clock, so the raw level may be compared directly
  assign rise_pulse = clock_en & level_in & ~last_reg;
  assign level_now  = level_in;
endmodule

//--- sipo_driver.sv
// Twelve-stage serial-in parallel-out driver with open-drain outputs
`include "sipo_driver_map.svh"

module sipo_driver
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        clock_en,
  input  wire logic        serial_data,
  input  wire logic        shift_clock,
  input  wire logic        latch_strobe,
  input  wire logic        output_enable_n,
  input  wire logic        output_enable_n_driven,
  output logic [11:0]      drive_outputs_out,
  output logic [11:0]      drive_outputs_oe,
  output logic             cascade_out,
  output logic             frame_valid
);

  // --------------------------------------------------------------------------
  // Pin edge detection
  // --------------------------------------------------------------------------
  logic shift_rise;
  logic latch_rise;
  logic latch_high;

  edge_catch u_shift_edge
  (
    .clock      (clock),
    .rst        (rst),
    .clock_en   (clock_en),
    .level_in   (shift_clock),
    .rise_pulse (shift_rise),
    .level_now  ()
  );

  edge_catch u_latch_edge
  (
    .clock      (clock),
    .rst        (rst),
    .clock_en   (clock_en),
    .level_in   (latch_strobe),
    .rise_pulse (latch_rise),
    .level_now  (latch_high)
  );

  // --------------------------------------------------------------------------
  // Shift and storage registers
  // --------------------------------------------------------------------------
  sipo_driver_pkg::stage_word_t shift_reg;
  sipo_driver_pkg::stage_word_t shift_next;
  sipo_driver_pkg::stage_word_t store_reg;
  sipo_driver_pkg::stage_word_t store_next;
  logic                         cascade_reg;
  logic                         cascade_next;

  function automatic sipo_driver_pkg::stage_word_t shift_in
  (
    input sipo_driver_pkg::stage_word_t word,
    input logic                         bit_in
  );
    shift_in = {word[`STAGE_MSB-1:0], bit_in};
  endfunction

  always_comb
  begin
    shift_next   = shift_reg;
    store_next   = store_reg;
    cascade_next = cascade_reg;
    if (clock_en)
    begin
      if (shift_rise)
      begin
        shift_next   = shift_in(shift_reg, serial_data);
        // Cascade follows the new last stage on the same rise as the shift
        cascade_next = shift_next[`LAST_STAGE];
      end
      // Otherwise shift_next keeps shift_reg
      // Level latch: transparent while the strobe is high, which begins at its rise.
      // The shift path never writes store_next.
      if (latch_rise || latch_high)
      begin
        store_next = shift_next;
      end
    end
  end

  // Without a reset pin the device powers up with arbitrary contents; the model
  // clears to a known value only so simulation starts clean.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      shift_reg   <= `STAGE_ZERO;
      store_reg   <= `STAGE_ZERO;
      cascade_reg <= 1'b0;
    end
    else
    begin
      shift_reg   <= shift_next;
      store_reg   <= store_next;
      cascade_reg <= cascade_next;
    end
  end

  // --------------------------------------------------------------------------
  // Frame tracking
  // --------------------------------------------------------------------------
  sipo_driver_pkg::fill_state_t fill_reg;
  sipo_driver_pkg::fill_state_t fill_next;
  logic [3:0]                   bit_cnt_reg;
  logic [3:0]                   bit_cnt_next;

  // Only reports whether a full frame preceded the strobe; the host owns that duty
  always_comb
  begin
    fill_next    = fill_reg;
    bit_cnt_next = bit_cnt_reg;
    if (clock_en)
    begin
      case (fill_reg)
        sipo_driver_pkg::FILL_EMPTY,
        sipo_driver_pkg::FILL_PARTIAL:
        begin
          if (shift_rise)
          begin
            bit_cnt_next = bit_cnt_reg + `FRAME_CNT_ONE;
            if (bit_cnt_next == `FRAME_BITS)
            begin
              fill_next = sipo_driver_pkg::FILL_FULL;
            end
            else
            begin
              fill_next = sipo_driver_pkg::FILL_PARTIAL;
            end
          end
        end
        sipo_driver_pkg::FILL_FULL:
        begin
          if (latch_rise)
          begin
            fill_next = sipo_driver_pkg::FILL_LATCHED;
          end
        end
        sipo_driver_pkg::FILL_LATCHED:
        begin
          fill_next = sipo_driver_pkg::FILL_LATCHED;
        end
        default:
        begin
          fill_next    = sipo_driver_pkg::FILL_EMPTY;
          bit_cnt_next = `FRAME_CNT_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      fill_reg    <= sipo_driver_pkg::FILL_EMPTY;
      bit_cnt_reg <= `FRAME_CNT_ZERO;
    end
    else
    begin
      fill_reg    <= fill_next;
      bit_cnt_reg <= bit_cnt_next;
    end
  end

  // --------------------------------------------------------------------------
  // Open-drain output stage
  // --------------------------------------------------------------------------
  logic [11:0] od_oe_reg;
  logic [11:0] od_oe_next;
  logic        oe_n_eff;
  logic        valid_reg;
  logic        valid_next;

  // Undriven enable pin reads as low through the internal pull-down
  assign oe_n_eff = output_enable_n_driven & output_enable_n;

  always_comb
  begin
    od_oe_next = od_oe_reg;
    valid_next = valid_reg;
    if (clock_en)
    begin
      valid_next = (fill_next == sipo_driver_pkg::FILL_LATCHED);
      if (oe_n_eff)
      begin
        od_oe_next = `STAGE_ZERO;
      end
      else
      begin
        // Pull down where the stored bit is 0
        od_oe_next = ~store_next;
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      od_oe_reg <= `STAGE_ZERO;
      valid_reg <= 1'b0;
    end
    else
    begin
      od_oe_reg <= od_oe_next;
      valid_reg <= valid_next;
    end
  end

  // Open-drain pins only ever drive low; the constant sits in a flop with no reset, loaded with zero on every clock
  logic [11:0] od_level_reg;

  always_ff @(posedge clock)
  begin
    od_level_reg <= `STAGE_ZERO;
  end

  assign drive_outputs_out = od_level_reg;
  assign drive_outputs_oe  = od_oe_reg;
  assign cascade_out       = cascade_reg;
  assign frame_valid       = valid_reg;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  property p_shift_moves;
    @(posedge clock) disable iff (rst)
      (clock_en && shift_rise) |=> (shift_reg == {$past(shift_reg[`STAGE_MSB-1:0]), $past(serial_data)});
  endproperty
  a_shift_moves: assert property (p_shift_moves)
    else $error("shift register did not take serial data");

  property p_shift_holds;
    @(posedge clock) disable iff (rst)
      !(clock_en && shift_rise) |=> $stable(shift_reg);
  endproperty
  a_shift_holds: assert property (p_shift_holds)
    else $error("shift register changed without a shift edge");

  property p_store_holds;
    @(posedge clock) disable iff (rst)
      !(clock_en && latch_high) |=> $stable(store_reg);
  endproperty
  a_store_holds: assert property (p_store_holds)
    else $error("storage changed while strobe low");

  property p_latch_copy;
    @(posedge clock) disable iff (rst)
      (clock_en && latch_rise && !shift_rise) |=> (store_reg == shift_reg);
  endproperty
  a_latch_copy: assert property (p_latch_copy)
    else $error("strobe rise did not copy shift register");

  property p_transparent;
    @(posedge clock) disable iff (rst)
      (clock_en && latch_high) [*2] |=> (store_reg == shift_reg);
  endproperty
  a_transparent: assert property (p_transparent)
    else $error("storage not renewed while strobe high");

  property p_disabled;
    @(posedge clock) disable iff (rst)
      (clock_en && oe_n_eff) |=> (drive_outputs_oe == `STAGE_ZERO);
  endproperty
  a_disabled: assert property (p_disabled)
    else $error("output driven while enable high");

  property p_enabled;
    @(posedge clock) disable iff (rst)
      (clock_en && !oe_n_eff) |=> (drive_outputs_oe == ~store_reg) && (drive_outputs_out == `STAGE_ZERO);
  endproperty
  a_enabled: assert property (p_enabled)
    else $error("outputs do not follow storage");

  property p_cascade;
    @(posedge clock) disable iff (rst)
      (clock_en && shift_rise) |=> (cascade_out == shift_reg[`LAST_STAGE]);
  endproperty
  a_cascade: assert property (p_cascade)
    else $error("cascade output not last stage");

  property p_pulldown;
    @(posedge clock) disable iff (rst)
      (clock_en && !output_enable_n_driven) |=> (drive_outputs_oe == ~store_reg);
  endproperty
  a_pulldown: assert property (p_pulldown)
    else $error("undriven enable did not enable outputs");

endmodule

//--- sipo_host_model.sv
// Host model that shifts frames and pulses the latch strobe
module sipo_host_model
(
  input  wire logic clock,
  output logic      serial_data,
  output logic      shift_clock,
  output logic      latch_strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  int gap;
  initial
  begin
    serial_data = 1'b0;
    shift_clock = 1'b0;
    latch_strobe = 1'b0;
    gap = 1;
  end
  // ------------------------------------------------------------
  // Pin tasks, all changes just after a falling edge
  // ------------------------------------------------------------
  task automatic shift_bit(input logic b);
    @(negedge clock);
    serial_data = b;
    shift_clock = 1'b1;
    repeat (gap) @(negedge clock);
    shift_clock = 1'b0;
    // Hold time is over once the clock is low, so the old bit is not kept
    serial_data = ~b;
    repeat (gap) @(negedge clock);
  endtask
  task automatic set_latch(input logic b);
    @(negedge clock);
    latch_strobe = b;
  endtask
  task automatic send_frame(input sipo_driver_pkg::stage_word_t w, input logic do_latch);
    for (int i = 11; i >= 0; i--)
    begin
      shift_bit(w[i]);
    end
    if (do_latch)
    begin
      set_latch(1'b1);
      repeat (gap) @(negedge clock);
      latch_strobe = 1'b0;
    end
  endtask
endmodule

//--- serial_in_parallel_out_driver_tb.sv
// Self-checking bench for the serial-in parallel-out driver
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin fails++; \
  $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module serial_in_parallel_out_driver_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock, rst, clock_en, output_enable_n, output_enable_n_driven;
  logic        serial_data, shift_clock, latch_strobe, cascade_out, frame_valid;
  logic [11:0] drive_outputs_out, drive_outputs_oe;
  logic [11:0] m_sr, m_st, m_oe, w;
  logic        m_cas, m_prev, m_fv, m_lprev;
  int          fails, tests_run;
  int          m_cnt;
  sipo_host_model host
  (
    .clock        (clock),
    .serial_data  (serial_data),
    .shift_clock  (shift_clock),
    .latch_strobe (latch_strobe)
  );
  sipo_driver dut
  (
    .clock                  (clock),
    .rst                    (rst),
    .clock_en               (clock_en),
    .serial_data            (serial_data),
    .shift_clock            (shift_clock),
    .latch_strobe           (latch_strobe),
    .output_enable_n        (output_enable_n),
    .output_enable_n_driven (output_enable_n_driven),
    .drive_outputs_out      (drive_outputs_out),
    .drive_outputs_oe       (drive_outputs_oe),
    .cascade_out            (cascade_out),
    .frame_valid            (frame_valid)
  );
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // ------------------------------------------------------------
  // Reference model, stepped on the same edge as the design
  // ------------------------------------------------------------
  always @(posedge clock)
  begin
    if (rst)
    begin
      m_sr = 12'h000; m_st = 12'h000; m_oe = 12'h000; m_cas = 1'b0; m_prev = 1'b0;
      m_cnt = 0;
      m_fv = 1'b0;
      m_lprev = 1'b0;
    end
    else if (clock_en)
    begin
      // A strobe counts as a frame load only after twelve earlier shifts
      if (latch_strobe && !m_lprev && m_cnt >= 12)
      begin
        m_fv = 1'b1;
      end
      m_lprev = latch_strobe;
      if (shift_clock && !m_prev)
      begin
        m_sr = {m_sr[10:0], serial_data};
        m_cnt++;
      end
      m_prev = shift_clock;
      if (latch_strobe)
      begin
        m_st = m_sr;
      end
      m_oe = (!output_enable_n_driven || !output_enable_n) ? ~m_st : 12'h000;
      m_cas = m_sr[11];
    end
  end
  always @(negedge clock)
  begin
    if (!rst)
    begin
      `CHK("oe", m_oe, drive_outputs_oe)
      `CHK("out", 12'h000, drive_outputs_out)
      `CHK("cascade", m_cas, cascade_out)
      `CHK("valid", m_fv, frame_valid)
    end
  end
  task automatic end_of_test();
    $display("Counts: %0d compared, %0d failed", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    #300000;
    fails++;
    end_of_test();
  end
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial
  begin
    rst = 1'b1; clock_en = 1'b1; output_enable_n = 1'b0; output_enable_n_driven = 1'b1;
    fails = 0; tests_run = 0;
    void'($urandom(17460));
    repeat (16) @(negedge clock);
    rst = 1'b0;
    `CHK("fv_reset", 1'b0, frame_valid)
    for (int k = 0; k < 4; k++)
    begin
      w = 12'($urandom);
      host.gap = k % 2 + 1;
      host.send_frame(w, 1'b1);
      `CHK("frame", ~w, drive_outputs_oe)
      `CHK("fv_set", 1'b1, frame_valid)
    end
    $display("test frames done");
    output_enable_n = 1'b1;
    host.send_frame(12'($urandom), 1'b0);
    `CHK("oe_off", 12'h000, drive_outputs_oe)
    output_enable_n_driven = 1'b0;
    repeat (2) @(negedge clock);
    `CHK("float_en", ~w, drive_outputs_oe)
    output_enable_n_driven = 1'b1;
    output_enable_n = 1'b0;
    $display("test enable done");
    w = 12'($urandom);
    host.gap = 5;
    host.send_frame(w, 1'b1);
    `CHK("slow", ~w, drive_outputs_oe)
    $display("test slow clock done");
    host.gap = 1;
    w = 12'($urandom);
    host.set_latch(1'b1);
    host.send_frame(w, 1'b0);
    repeat (2) @(negedge clock);
    `CHK("transp", ~w, drive_outputs_oe)
    host.set_latch(1'b0);
    repeat (3) host.shift_bit(1'($urandom));
    `CHK("held", ~w, drive_outputs_oe)
    $display("test transparent latch done");
    clock_en = 1'b0;
    output_enable_n = 1'b1;
    host.shift_bit(1'b1);
    `CHK("freeze", ~w, drive_outputs_oe)
    output_enable_n = 1'b0;
    clock_en = 1'b1;
    $display("test freeze done");
    rst = 1'b1;
    repeat (2) @(negedge clock);
    `CHK("rst_oe", 12'h000, drive_outputs_oe)
    `CHK("rst_fv", 1'b0, frame_valid)
    rst = 1'b0;
    repeat (5) host.shift_bit(1'($urandom));
    host.set_latch(1'b1);
    host.set_latch(1'b0);
    `CHK("fv_early", 1'b0, frame_valid)
    host.send_frame(12'hA5C, 1'b1);
    `CHK("after_rst", 12'h5A3, drive_outputs_oe)
    `CHK("fv_after", 1'b1, frame_valid)
    $display("test second reset done");
    end_of_test();
  end
endmodule
